// File: hw/csp_pkg.sv
// Constants, types and helper functions of the configurable serial port.
package csp_pkg;
  // Clock and line rate.
  localparam int unsigned CSP_CLK_HZ     = 200_000_000;
  localparam int unsigned CSP_BAUD_MIN   = 110;
  localparam int unsigned CSP_BAUD_MAX   = 230_400;
  localparam int unsigned CSP_BAUD_DEF   = 115_200;
  localparam int unsigned CSP_DIV_MAX    = CSP_CLK_HZ / CSP_BAUD_MIN;
  localparam logic [20:0] CSP_DIV_MIN    = 21'(CSP_CLK_HZ / CSP_BAUD_MAX);
  localparam logic [20:0] CSP_DIV_DEF    = 21'(CSP_CLK_HZ / CSP_BAUD_DEF);
  // Character format and buffering.
  localparam int          CSP_FIFO_DEPTH = 16;
  localparam logic [2:0]  CSP_LAST_OFS   = 3'h4;
  localparam logic [2:0]  CSP_HALF_BIT   = 3'h2;
  localparam logic [2:0]  CSP_HALF_S15   = 3'h3;
  localparam logic [2:0]  CSP_HALF_S2    = 3'h4;
  // Register byte offsets.
  localparam logic [7:0]  CSP_OFS_DATA   = 8'h00;
  localparam logic [7:0]  CSP_OFS_CFG    = 8'h04;
  localparam logic [7:0]  CSP_OFS_DIV    = 8'h08;
  localparam logic [7:0]  CSP_OFS_STAT   = 8'h0C;
  // Status and data read bit positions.
  localparam int          CSP_ST_TXE     = 0;
  localparam int          CSP_ST_TXF     = 1;
  localparam int          CSP_ST_RXA     = 2;
  localparam int          CSP_ST_BUSY    = 3;
  localparam int          CSP_ST_OVR     = 4;
  localparam int          CSP_ST_PERR    = 5;
  localparam int          CSP_ST_FERR    = 6;
  localparam int          CSP_RD_VALID   = 10;

  typedef enum logic [2:0] {
    CSP_PAR_NONE  = 3'h0,
    CSP_PAR_EVEN  = 3'h1,
    CSP_PAR_ODD   = 3'h2,
    CSP_PAR_SPACE = 3'h3,
    CSP_PAR_MARK  = 3'h4
  } csp_parity_type;

  typedef struct packed {
    logic           fifo_en;
    csp_parity_type parity;
    logic           stop_two;
    logic [1:0]     width;
  } csp_cfg_type;

  localparam int CSP_CFG_W = $bits(csp_cfg_type);
  localparam csp_cfg_type CSP_CFG_RST = '{fifo_en: 1'b1, parity: CSP_PAR_NONE, stop_two: 1'b0, width: 2'h3};

  typedef struct packed {
    logic       frame_err;
    logic       par_err;
    logic [7:0] data;
  } csp_rx_char_type;

  function automatic logic [7:0] csp_mask(input logic [7:0] d, input logic [1:0] w);
    csp_mask = d & (8'hFF >> (2'h3 - w));
  endfunction

  function automatic logic csp_parity(input logic [7:0] d, input csp_cfg_type c);
    case (c.parity)
      CSP_PAR_EVEN: csp_parity = ^csp_mask(d, c.width);
      CSP_PAR_ODD:  csp_parity = ~^csp_mask(d, c.width);
      CSP_PAR_MARK: csp_parity = 1'b1;
      default:      csp_parity = 1'b0;
    endcase
  endfunction

  function automatic logic [2:0] csp_stop_halves(input csp_cfg_type c);
    if (c.width == 2'h0) begin
      csp_stop_halves = CSP_HALF_S15;
    end else if (c.stop_two) begin
      csp_stop_halves = CSP_HALF_S2;
    end else begin
      csp_stop_halves = CSP_HALF_BIT;
    end
  endfunction
endpackage

// File: hw/csp_fifo.sv
// Parameterised first-in first-out buffer with valid and ready on both sides.
`timescale 1ns/1ps
module csp_fifo import csp_pkg::*; #(
  parameter int W     = 8,
  parameter int DEPTH = CSP_FIFO_DEPTH
) (
  // Clock and control
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic         ce,
  input  wire logic         single,
  // Filling side
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  // Draining side
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] wr_next;
  logic [AW-1:0] rd_reg;
  logic [AW-1:0] rd_next;
  logic [AW:0]   cnt_reg;
  logic [AW:0]   cnt_next;
  logic          push;
  logic          pop;

  // With buffering off one entry is used, so each character is handed over alone.
  assign in_ready  = single ? (cnt_reg == '0) : (cnt_reg != (AW+1)'(DEPTH));
  assign out_valid = cnt_reg != '0;
  assign out_data  = mem[rd_reg];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_comb begin
    wr_next  = wr_reg;
    rd_next  = rd_reg;
    cnt_next = cnt_reg;
    if (push) begin
      wr_next = (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
    end
    if (pop) begin
      rd_next = (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
    end
    if (push && !pop) begin
      cnt_next = cnt_reg + 1'b1;
    end else if (pop && !push) begin
      cnt_next = cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else if (ce) begin
      wr_reg  <= wr_next;
      rd_reg  <= rd_next;
      cnt_reg <= cnt_next;
    end
  end

  always_ff @(posedge hclk) begin
    if (ce && push) begin
      mem[wr_reg] <= in_data;
    end
  end
endmodule

// File: hw/csp_tx.sv
// Serial transmitter that frames one character at a time onto the line.
`timescale 1ns/1ps
module csp_tx import csp_pkg::*; (
  // Clock and control
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  input  wire logic [19:0] half_div,
  input  wire csp_cfg_type cfg,
  // Character stream
  input  wire logic        in_valid,
  input  wire logic [7:0]  in_data,
  output logic             in_ready,
  // Line side
  output logic             txd,
  output logic             busy
);
  typedef enum logic [4:0] {
    CSP_TX_IDLE  = 5'b00001,
    CSP_TX_START = 5'b00010,
    CSP_TX_DATA  = 5'b00100,
    CSP_TX_PAR   = 5'b01000,
    CSP_TX_STOP  = 5'b10000
  } csp_tx_state_type;

  csp_tx_state_type st_reg;
  csp_tx_state_type st_next;
  csp_cfg_type      cfg_reg;
  csp_cfg_type      cfg_next;
  logic [19:0]      cnt_reg;
  logic [19:0]      cnt_next;
  logic [2:0]       half_reg;
  logic [2:0]       half_next;
  logic [2:0]       bit_reg;
  logic [2:0]       bit_next;
  logic [7:0]       sh_reg;
  logic [7:0]       sh_next;
  logic             par_reg;
  logic             par_next;
  logic             txd_reg;
  logic             txd_next;
  logic             bit_end;

  assign in_ready = st_reg == CSP_TX_IDLE;
  assign busy     = st_reg != CSP_TX_IDLE;
  assign txd      = txd_reg;

  always_comb begin
    st_next   = st_reg;
    cfg_next  = cfg_reg;
    cnt_next  = cnt_reg;
    half_next = half_reg;
    bit_next  = bit_reg;
    sh_next   = sh_reg;
    par_next  = par_reg;
    txd_next  = txd_reg;
    bit_end   = 1'b0;
    if (st_reg != CSP_TX_IDLE) begin
      if (cnt_reg == half_div - 20'h1) begin
        cnt_next  = '0;
        half_next = half_reg - 3'h1;
        bit_end   = half_reg == 3'h1;
      end else begin
        cnt_next = cnt_reg + 20'h1;
      end
    end
    case (st_reg)
      CSP_TX_IDLE: begin
        if (in_valid) begin
          // The format is latched per character so a change never splits one.
          cfg_next  = cfg;
          sh_next   = in_data;
          par_next  = csp_parity(in_data, cfg);
          txd_next  = 1'b0;
          cnt_next  = '0;
          half_next = CSP_HALF_BIT;
          st_next   = CSP_TX_START;
        end
      end
      CSP_TX_START: begin
        if (bit_end) begin
          txd_next  = sh_reg[0];
          bit_next  = '0;
          half_next = CSP_HALF_BIT;
          st_next   = CSP_TX_DATA;
        end
      end
      CSP_TX_DATA: begin
        if (bit_end) begin
          half_next = CSP_HALF_BIT;
          if (bit_reg == 3'(cfg_reg.width) + CSP_LAST_OFS) begin
            if (cfg_reg.parity != CSP_PAR_NONE) begin
              txd_next = par_reg;
              st_next  = CSP_TX_PAR;
            end else begin
              txd_next  = 1'b1;
              half_next = csp_stop_halves(cfg_reg);
              st_next   = CSP_TX_STOP;
            end
          end else begin
            sh_next  = sh_reg >> 1;
            txd_next = sh_reg[1];
            bit_next = bit_reg + 3'h1;
          end
        end
      end
      CSP_TX_PAR: begin
        if (bit_end) begin
          txd_next  = 1'b1;
          half_next = csp_stop_halves(cfg_reg);
          st_next   = CSP_TX_STOP;
        end
      end
      CSP_TX_STOP: begin
        if (bit_end) begin
          st_next = CSP_TX_IDLE;
        end
      end
      default: begin
        st_next  = CSP_TX_IDLE;
        txd_next = 1'b1;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg   <= CSP_TX_IDLE;
      cfg_reg  <= CSP_CFG_RST;
      cnt_reg  <= '0;
      half_reg <= '0;
      bit_reg  <= '0;
      sh_reg   <= '0;
      par_reg  <= 1'b0;
      txd_reg  <= 1'b1;
    end else if (ce) begin
      st_reg   <= st_next;
      cfg_reg  <= cfg_next;
      cnt_reg  <= cnt_next;
      half_reg <= half_next;
      bit_reg  <= bit_next;
      sh_reg   <= sh_next;
      par_reg  <= par_next;
      txd_reg  <= txd_next;
    end
  end
endmodule

// File: hw/csp_serial_port.sv
// Configurable serial port with AHB-Lite registers, receiver and two FIFOs.
`timescale 1ns/1ps
module csp_serial_port import csp_pkg::*; #(
  parameter int unsigned DIV_MAX = CSP_DIV_MAX,
  parameter int          DEPTH   = CSP_FIFO_DEPTH
) (
  // Clock, reset and enable
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // Serial line
  input  wire logic        rxd,
  output logic             txd
);
  typedef enum logic [4:0] {
    CSP_RX_IDLE  = 5'b00001,
    CSP_RX_START = 5'b00010,
    CSP_RX_DATA  = 5'b00100,
    CSP_RX_PAR   = 5'b01000,
    CSP_RX_STOP  = 5'b10000
  } csp_rx_state_type;

  localparam int RXW = $bits(csp_rx_char_type);

  // Bus and register state.
  logic            pend_reg;
  logic            pend_next;
  logic            pw_reg;
  logic            pw_next;
  logic [7:0]      pa_reg;
  logic [7:0]      pa_next;
  logic            rdy_reg;
  logic            rdy_next;
  logic [31:0]     rd_reg;
  logic [31:0]     rd_next;
  csp_cfg_type     cfg_reg;
  csp_cfg_type     cfg_next;
  logic [20:0]     div_reg;
  logic [20:0]     div_next;
  logic            ovr_reg;
  logic            ovr_next;
  logic            perr_reg;
  logic            perr_next;
  logic            ferr_reg;
  logic            ferr_next;
  logic [20:0]     div_wr;
  logic            tx_push;
  logic            rx_pop;

  // Receiver state.
  logic            s1_reg;
  logic            s2_reg;
  csp_rx_state_type rst_reg;
  csp_rx_state_type rst_next;
  csp_cfg_type     rcfg_reg;
  csp_cfg_type     rcfg_next;
  logic [20:0]     rcnt_reg;
  logic [20:0]     rcnt_next;
  logic [2:0]      rbit_reg;
  logic [2:0]      rbit_next;
  logic [7:0]      rsh_reg;
  logic [7:0]      rsh_next;
  logic            rpar_reg;
  logic            rpar_next;
  logic            rx_push;
  csp_rx_char_type rx_char;

  // FIFO connections.
  logic            tx_in_ready;
  logic            tx_out_valid;
  logic [7:0]      tx_out_data;
  logic            tx_take;
  logic            tx_busy;
  logic            rx_in_ready;
  logic            rx_out_valid;
  logic [RXW-1:0]  rx_out_data;

  assign hreadyout = rdy_reg;
  assign hrdata    = rd_reg;
  assign hresp     = 1'b0;
  assign div_wr    = hwdata[20:0];

  always_comb begin
    pend_next = pend_reg;
    pw_next   = pw_reg;
    pa_next   = pa_reg;
    rdy_next  = rdy_reg;
    rd_next   = rd_reg;
    cfg_next  = cfg_reg;
    div_next  = div_reg;
    tx_push   = 1'b0;
    rx_pop    = 1'b0;
    ovr_next  = ovr_reg;
    perr_next = perr_reg;
    ferr_next = ferr_reg;
    if (pend_reg) begin
      if (pw_reg && pa_reg == CSP_OFS_DATA) begin
        // A full transmit FIFO holds the bus in wait states instead of dropping data.
        if (tx_in_ready) begin
          tx_push   = 1'b1;
          pend_next = 1'b0;
          rdy_next  = 1'b1;
        end
      end else begin
        pend_next = 1'b0;
        rdy_next  = 1'b1;
        if (pw_reg) begin
          if (pa_reg == CSP_OFS_CFG) begin
            cfg_next = csp_cfg_type'(hwdata[CSP_CFG_W-1:0]);
          end else if (pa_reg == CSP_OFS_DIV) begin
            if (div_wr < CSP_DIV_MIN) begin
              div_next = CSP_DIV_MIN;
            end else if (div_wr > 21'(DIV_MAX)) begin
              div_next = 21'(DIV_MAX);
            end else begin
              div_next = div_wr;
            end
          end else if (pa_reg == CSP_OFS_STAT) begin
            ovr_next  = ovr_reg & ~hwdata[CSP_ST_OVR];
            perr_next = perr_reg & ~hwdata[CSP_ST_PERR];
            ferr_next = ferr_reg & ~hwdata[CSP_ST_FERR];
          end
        end else begin
          rd_next = '0;
          if (pa_reg == CSP_OFS_DATA) begin
            rx_pop                = rx_out_valid;
            rd_next[RXW-1:0]      = rx_out_data;
            rd_next[CSP_RD_VALID] = rx_out_valid;
          end else if (pa_reg == CSP_OFS_CFG) begin
            rd_next[CSP_CFG_W-1:0] = cfg_reg;
          end else if (pa_reg == CSP_OFS_DIV) begin
            rd_next[20:0] = div_reg;
          end else if (pa_reg == CSP_OFS_STAT) begin
            rd_next[CSP_ST_TXE]  = !tx_out_valid;
            rd_next[CSP_ST_TXF]  = !tx_in_ready;
            rd_next[CSP_ST_RXA]  = rx_out_valid;
            rd_next[CSP_ST_BUSY] = tx_busy;
            rd_next[CSP_ST_OVR]  = ovr_reg;
            rd_next[CSP_ST_PERR] = perr_reg;
            rd_next[CSP_ST_FERR] = ferr_reg;
          end
        end
      end
    end else if (hsel && hready && htrans[1]) begin
      pend_next = 1'b1;
      pw_next   = hwrite;
      pa_next   = {haddr[7:2], 2'h0};
      rdy_next  = 1'b0;
    end
    // A receiver event in the clearing cycle keeps its flag set.
    if (rx_push) begin
      ovr_next  = ovr_next | !rx_in_ready;
      perr_next = perr_next | rx_char.par_err;
      ferr_next = ferr_next | rx_char.frame_err;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_reg <= 1'b0;
      pw_reg   <= 1'b0;
      pa_reg   <= '0;
      rdy_reg  <= 1'b1;
      rd_reg   <= '0;
      cfg_reg  <= CSP_CFG_RST;
      div_reg  <= CSP_DIV_DEF;
      ovr_reg  <= 1'b0;
      perr_reg <= 1'b0;
      ferr_reg <= 1'b0;
    end else if (ce) begin
      pend_reg <= pend_next;
      pw_reg   <= pw_next;
      pa_reg   <= pa_next;
      rdy_reg  <= rdy_next;
      rd_reg   <= rd_next;
      cfg_reg  <= cfg_next;
      div_reg  <= div_next;
      ovr_reg  <= ovr_next;
      perr_reg <= perr_next;
      ferr_reg <= ferr_next;
    end
  end

  // Receiver samples each bit at its centre; only the first stop bit is checked.
  assign rx_char.data      = rsh_reg >> (2'h3 - rcfg_reg.width);
  assign rx_char.par_err   = (rcfg_reg.parity != CSP_PAR_NONE) &&
                             (rpar_reg != csp_parity(rx_char.data, rcfg_reg));
  assign rx_char.frame_err = !s2_reg;

  always_comb begin
    rst_next  = rst_reg;
    rcfg_next = rcfg_reg;
    rcnt_next = rcnt_reg + 21'h1;
    rbit_next = rbit_reg;
    rsh_next  = rsh_reg;
    rpar_next = rpar_reg;
    rx_push   = 1'b0;
    case (rst_reg)
      CSP_RX_IDLE: begin
        rcnt_next = '0;
        if (!s2_reg) begin
          rcfg_next = cfg_reg;
          rst_next  = CSP_RX_START;
        end
      end
      CSP_RX_START: begin
        if (rcnt_reg == (div_reg >> 1) - 21'h1) begin
          rcnt_next = '0;
          rbit_next = '0;
          rst_next  = s2_reg ? CSP_RX_IDLE : CSP_RX_DATA;
        end
      end
      CSP_RX_DATA: begin
        if (rcnt_reg == div_reg - 21'h1) begin
          rcnt_next = '0;
          rsh_next  = {s2_reg, rsh_reg[7:1]};
          rbit_next = rbit_reg + 3'h1;
          if (rbit_reg == 3'(rcfg_reg.width) + CSP_LAST_OFS) begin
            rst_next = (rcfg_reg.parity != CSP_PAR_NONE) ? CSP_RX_PAR : CSP_RX_STOP;
          end
        end
      end
      CSP_RX_PAR: begin
        if (rcnt_reg == div_reg - 21'h1) begin
          rcnt_next = '0;
          rpar_next = s2_reg;
          rst_next  = CSP_RX_STOP;
        end
      end
      CSP_RX_STOP: begin
        if (rcnt_reg == div_reg - 21'h1) begin
          rx_push  = 1'b1;
          rst_next = CSP_RX_IDLE;
        end
      end
      default: begin
        rst_next = CSP_RX_IDLE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_reg   <= 1'b1;
      s2_reg   <= 1'b1;
      rst_reg  <= CSP_RX_IDLE;
      rcfg_reg <= CSP_CFG_RST;
      rcnt_reg <= '0;
      rbit_reg <= '0;
      rsh_reg  <= '0;
      rpar_reg <= 1'b0;
    end else if (ce) begin
      s1_reg   <= rxd;
      s2_reg   <= s1_reg;
      rst_reg  <= rst_next;
      rcfg_reg <= rcfg_next;
      rcnt_reg <= rcnt_next;
      rbit_reg <= rbit_next;
      rsh_reg  <= rsh_next;
      rpar_reg <= rpar_next;
    end
  end

  // Transmit path: bus writes fill, the transmitter drains.
  csp_fifo #(
    .W     (8),
    .DEPTH (DEPTH)
  ) u_tx_fifo (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .ce        (ce),
    .single    (!cfg_reg.fifo_en),
    .in_valid  (tx_push),
    .in_data   (hwdata[7:0]),
    .in_ready  (tx_in_ready),
    .out_valid (tx_out_valid),
    .out_data  (tx_out_data),
    .out_ready (tx_take)
  );

  csp_tx u_tx (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .ce       (ce),
    .half_div (div_reg[20:1]),
    .cfg      (cfg_reg),
    .in_valid (tx_out_valid),
    .in_data  (tx_out_data),
    .in_ready (tx_take),
    .txd      (txd),
    .busy     (tx_busy)
  );

  // Receive path: a character that finds the FIFO full is dropped and flagged.
  csp_fifo #(
    .W     (RXW),
    .DEPTH (DEPTH)
  ) u_rx_fifo (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .ce        (ce),
    .single    (!cfg_reg.fifo_en),
    .in_valid  (rx_push),
    .in_data   (rx_char),
    .in_ready  (rx_in_ready),
    .out_valid (rx_out_valid),
    .out_data  (rx_out_data),
    .out_ready (rx_pop)
  );
endmodule

// File: bench/csp_serial_port_props.sv
// Concurrent checks on the serial port's bus answers and line output.
`timescale 1ns/1ps
module csp_serial_port_chk import csp_pkg::*; #(
  parameter int unsigned DIV_MAX = CSP_DIV_MAX
) (
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        ce,
  // Bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  // Line
  input wire logic        txd
);
  localparam int MIN_BIT = int'(CSP_DIV_MIN) / 2 * 2;
  logic [31:0] low_reg;
  logic [31:0] low_next;
  logic        take;
  assign take = hsel && hready && htrans[1] && ce;
  // A low run on the line is counted so that bit lengths can be bounded at every rising edge.
  always_comb begin
    low_next = txd ? 32'h0 : low_reg + 32'h1;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      low_reg <= 32'h0;
    end else begin
      low_reg <= low_next;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_rd(logic [7:0] ofs);
    take && !hwrite && haddr[7:2] == ofs[7:2];
  endsequence
  sequence s_ans;
    1'b1 ##1 !hreadyout ##1 hreadyout;
  endsequence
  property p_reset;
    $rose(hresetn) |-> txd && hreadyout && hrdata == 32'h0;
  endproperty
  a_reset: assert property (p_reset) else $error("line or bus not idle after reset");
  property p_div_rd;
    s_rd(CSP_OFS_DIV) |-> s_ans ##0 (hrdata >= CSP_DIV_MIN && hrdata <= DIV_MAX);
  endproperty
  a_div_rd: assert property (p_div_rd) else $error("divisor read out of range");
  property p_bit_len;
    $rose(txd) |-> low_reg >= MIN_BIT && low_reg <= 10 * DIV_MAX;
  endproperty
  a_bit_len: assert property (p_bit_len) else $error("low run on line has bad length");
  property p_cfg_rd;
    s_rd(CSP_OFS_CFG) |-> s_ans ##0 (hrdata[31:7] == 25'h0);
  endproperty
  a_cfg_rd: assert property (p_cfg_rd) else $error("config read late or too wide");
  property p_cfg_wr;
    take && hwrite && haddr[7:2] == CSP_OFS_CFG[7:2] |-> s_ans;
  endproperty
  a_cfg_wr: assert property (p_cfg_wr) else $error("config write not answered in time");
  property p_stat_rd;
    s_rd(CSP_OFS_STAT) |-> s_ans ##0 !(hrdata[CSP_ST_TXE] && hrdata[CSP_ST_TXF]) && hrdata[31:7] == 25'h0;
  endproperty
  a_stat_rd: assert property (p_stat_rd) else $error("status shows empty and full at once");
  property p_data_rd;
    s_rd(CSP_OFS_DATA) |-> s_ans ##0 (hrdata[31:11] == 21'h0);
  endproperty
  a_data_rd: assert property (p_data_rd) else $error("data read too wide");
endmodule

bind csp_serial_port csp_serial_port_chk #(.DIV_MAX(DIV_MAX)) u_chk (
  .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .txd(txd));

// File: bench/csp_line_dev.sv
// Behavioural serial device that decodes the port's output line and drives its input line.
`timescale 1ns/1ps
module csp_line_dev import csp_pkg::*; (
  // Clock and format
  input  wire logic        hclk,
  input  wire csp_cfg_type fmt,
  input  wire logic [20:0] div,
  // Serial line
  input  wire logic        txd,
  output logic             rxd
);
  logic [9:0] rx_q[$];
  int         st_q[$];
  int         cyc = 0;
  logic [9:0] frm;
  initial rxd = 1'b1;
  always @(posedge hclk) cyc++;
  // Each frame is sampled at bit centres; the first stop bit lands in the top decoded position.
  always begin
    @(negedge txd);
    st_q.push_back(cyc);
    frm = 10'h0;
    repeat (div / 2) @(posedge hclk);
    for (int i = 0; i < 6 + int'(fmt.width) + int'(fmt.parity != CSP_PAR_NONE); i++) begin
      repeat (div) @(posedge hclk);
      frm[i] = txd;
    end
    rx_q.push_back(frm);
  end
  // The idle gap lets the bench send either promptly or slowly.
  task automatic send(input logic [7:0] d, input logic pbit, input int gap);
    int nb;
    nb = 5 + int'(fmt.width);
    repeat (gap) @(posedge hclk);
    rxd <= 1'b0;
    repeat (div) @(posedge hclk);
    for (int k = 0; k < nb + int'(fmt.parity != CSP_PAR_NONE); k++) begin
      rxd <= (k < nb) ? d[k] : pbit;
      repeat (div) @(posedge hclk);
    end
    rxd <= 1'b1;
    repeat (div) @(posedge hclk);
  endtask
endmodule

// File: bench/tb.sv
// Self-checking bench for the serial port: bus master, frame model and comparisons.
`timescale 1ns/1ps
module tb;
  import csp_pkg::*;
  localparam int unsigned DMAX = 4096;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        ce = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        hresp;
  logic        rxd;
  logic        txd;
  csp_cfg_type fmt = CSP_CFG_RST;
  logic [20:0] div = 21'h364;
  logic [31:0] rd;
  int          exp_q[$];
  int          fail_count = 0;
  int          cmp_count = 0;
  always #2.5 hclk = ~hclk;
  csp_serial_port #(.DIV_MAX(DMAX), .DEPTH(CSP_FIFO_DEPTH)) dut (.hclk(hclk), .hresetn(hresetn), .ce(ce),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .rxd(rxd), .txd(txd));
  csp_line_dev dev (.hclk(hclk), .fmt(fmt), .div(div), .txd(txd), .rxd(rxd));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // A wait ends only when hreadyout is high, so a stalled answer is counted as a failure by the watchdog.
  task automatic wait_rdy;
    do begin
      @(posedge hclk);
    end while (hreadyout !== 1'b1);
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
    chk(hresp, 1'b0);
  endtask
  task automatic do_reset;
    hresetn <= 1'b0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
  endtask
  task automatic defaults;
    bus(1'b0, CSP_OFS_CFG, 32'h0);
    chk(rd, 32'h43);
    bus(1'b0, CSP_OFS_DIV, 32'h0);
    chk(rd, 32'h6C8);
    bus(1'b1, 8'h10, 32'hFF);
    bus(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h0);
  endtask
  // Status is read after every write so the exact entry that fills the buffer is seen.
  task automatic fill(input int n);
    for (int i = 1; i <= n; i++) begin
      bus(1'b1, CSP_OFS_DATA, $urandom());
      bus(1'b0, CSP_OFS_STAT, 32'h0);
      chk(rd[CSP_ST_TXF], i == n);
    end
  endtask
  function automatic logic exp_par(input logic [7:0] d, input int nb, input int p);
    logic x;
    x = ^(d & 8'((1 << nb) - 1));
    case (p)
      1: exp_par = x;
      2: exp_par = ~x;
      4: exp_par = 1'b1;
      default: exp_par = 1'b0;
    endcase
  endfunction
  task automatic test_done;
    $display("comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge hclk);
    fail_count++;
    test_done();
  end
  initial begin
    logic [7:0] cfgs[3];
    logic [7:0] a;
    logic [7:0] b;
    int         nb;
    int         pe;
    int         len;
    cfgs = '{8'h4C, 8'h56, 8'h63};
    void'($urandom(29));
    do_reset();
    defaults();
    bus(1'b1, CSP_OFS_DIV, 32'h64);
    bus(1'b0, CSP_OFS_DIV, 32'h0);
    chk(rd, 32'h364);
    bus(1'b1, CSP_OFS_DIV, 32'h1FFFFF);
    bus(1'b0, CSP_OFS_DIV, 32'h0);
    chk(rd, DMAX);
    len = $urandom_range(4000, 1000);
    bus(1'b1, CSP_OFS_DIV, len);
    bus(1'b0, CSP_OFS_DIV, 32'h0);
    chk(rd, len);
    bus(1'b1, CSP_OFS_DIV, 32'h364);
    // The first format has five bits with two stop bits asked, which must come out as one and a half.
    foreach (cfgs[c]) begin
      fmt = csp_cfg_type'(cfgs[c][6:0]);
      nb = 5 + int'(cfgs[c][1:0]);
      pe = int'(cfgs[c][5:3]);
      bus(1'b1, CSP_OFS_CFG, {24'h0, cfgs[c]});
      dev.rx_q.delete();
      dev.st_q.delete();
      exp_q.delete();
      for (int k = 0; k < 2; k++) begin
        a = $urandom();
        bus(1'b1, CSP_OFS_DATA, {24'h0, a});
        exp_q.push_back((a & ((1 << nb) - 1)) | (int'(exp_par(a, nb, pe)) << nb) | (1 << (nb + 1)));
      end
      for (int n = 0; n < 30000 && dev.rx_q.size() < 2; n++) @(posedge hclk);
      for (int k = 0; k < 2; k++) chk(dev.rx_q[k], exp_q[k]);
      len = dev.st_q[1] - dev.st_q[0] - (2 + nb) * 868 - (nb == 5 ? 3 : 2 + 2 * int'(cfgs[c][2])) * 434;
      chk(len >= 0 && len <= 2, 1'b1);
    end
    fmt = csp_cfg_type'(7'h1B);
    bus(1'b1, CSP_OFS_CFG, 32'h1B);
    a = $urandom();
    b = $urandom();
    dev.send(a, 1'b0, 0);
    dev.send(b, 1'b1, 0);
    bus(1'b0, CSP_OFS_STAT, 32'h0);
    chk(rd[CSP_ST_OVR], 1'b1);
    bus(1'b0, CSP_OFS_DATA, 32'h0);
    chk(rd, 32'h400 | {24'h0, a});
    bus(1'b1, CSP_OFS_STAT, 32'h70);
    dev.send(b, 1'b1, 300);
    bus(1'b0, CSP_OFS_DATA, 32'h0);
    chk(rd, 32'h500 | {24'h0, b});
    fmt = CSP_CFG_RST;
    bus(1'b1, CSP_OFS_CFG, 32'h43);
    dev.send(a, 1'b0, 0);
    bus(1'b0, CSP_OFS_DATA, 32'h0);
    chk(rd, 32'h400 | {24'h0, a});
    bus(1'b0, CSP_OFS_DATA, 32'h0);
    chk(rd[CSP_RD_VALID], 1'b0);
    fill(17);
    do_reset();
    defaults();
    bus(1'b1, CSP_OFS_CFG, 32'h03);
    fill(2);
    test_done();
  end
endmodule
